/* inc/tlc_pkg.sv */
// constants and types for the tolerance limit comparator
// assumes one 20 MHz clock, synchronous active-low reset, pulsed key inputs
//
// Contract
// - a commit whose lower limit exceeds the upper limit is refused and the old limits stay.
// - neither limit may be stored above 110 percent of the rated capacity.
// - a sample below the lower limit turns the under-limit switch on.
// - a sample above the upper limit or above 110 percent of capacity turns the over-limit switch on.
// - judgement is enabled only once a valid pair of limits has been committed; the 110 percent capacity check turns the over-limit switch on before that.
// - while editing, one key steps the selected digit and another moves to the next digit.
// - cancel drops pending edits, confirm stores the limits and leaves edit mode.
// - pass, under and over each have their own distinct indication.
package tlc_pkg;
    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int DIGITS = 5;
    localparam int DIG_W = 4;
    localparam int BCD_W = DIGITS * DIG_W;
    localparam int VAL_W = 20;
    localparam int IDX_W = 3;
    // ----------------------------------------
    // fixed values
    // ----------------------------------------
    localparam logic [DIG_W-1:0] DIGIT_MAX = 4'h9;
    localparam logic [IDX_W-1:0] IDX_LAST = 3'h4;
    localparam logic [VAL_W-1:0] LIMIT_RESET = 20'h00000;
    localparam logic [VAL_W+6:0] PCT_OVER = 27'h000006E;
    localparam logic [VAL_W+6:0] PCT_FULL = 27'h0000064;
    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        TLC_IDLE = 2'b00,
        TLC_EDIT_LO = 2'b01,
        TLC_EDIT_HI = 2'b11
    } tlc_state_t;
    typedef enum logic [1:0] {
        TLC_J_NONE = 2'b00,
        TLC_J_UNDER = 2'b01,
        TLC_J_PASS = 2'b10,
        TLC_J_OVER = 2'b11
    } tlc_judge_t;
endpackage : tlc_pkg

/* src/tlc_bcd_to_bin.sv */
// converts a packed BCD edit buffer into binary
// assumes valid digits, 0 to 9 each
`timescale 1ns/1ps
module tlc_bcd_to_bin (
    input wire logic [tlc_pkg::BCD_W-1:0] bcd_in,
    output logic [tlc_pkg::VAL_W-1:0] bin_out
);
    always_comb begin
        bin_out = '0;
        for (int i = tlc_pkg::DIGITS - 1; i >= 0; i--) begin
            bin_out = tlc_pkg::VAL_W'(bin_out * 10)
                    + tlc_pkg::VAL_W'(bcd_in[i*tlc_pkg::DIG_W +: tlc_pkg::DIG_W]);
        end
    end
endmodule : tlc_bcd_to_bin

/* src/tlc_comparator.sv */
// limit entry, validity check and under/over judgement of each sample
// assumes sample_valid_in pulses once per sample and key inputs are one-cycle pulses
`timescale 1ns/1ps
module tlc_comparator (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [tlc_pkg::VAL_W-1:0] capacity_in,
    input wire logic sample_valid_in,
    input wire logic [tlc_pkg::VAL_W-1:0] sample_in,
    input wire logic key_preset_in,
    input wire logic key_step_in,
    input wire logic key_next_in,
    input wire logic key_cancel_in,
    input wire logic key_confirm_in,
    output logic editing_out,
    output logic edit_high_out,
    output logic [tlc_pkg::IDX_W-1:0] digit_sel_out,
    output logic [tlc_pkg::BCD_W-1:0] edit_bcd_out,
    output logic commit_refused_out,
    output logic judge_enabled_out,
    output logic [tlc_pkg::VAL_W-1:0] limit_low_out,
    output logic [tlc_pkg::VAL_W-1:0] limit_high_out,
    output logic under_limit_switch_out,
    output logic over_limit_switch_out,
    output logic [1:0] pass_fail_judgement_out
);
    // ----------------------------------------
    // edit state
    // ----------------------------------------
    tlc_pkg::tlc_state_t state_ff, nxt_state;
    logic [tlc_pkg::IDX_W-1:0] digit_ff, nxt_digit;
    logic [tlc_pkg::BCD_W-1:0] buf_lo_ff, nxt_buf_lo, buf_hi_ff, nxt_buf_hi;
    logic [tlc_pkg::VAL_W-1:0] lim_lo_ff, nxt_lim_lo, lim_hi_ff, nxt_lim_hi;
    logic en_ff, nxt_en, refused_ff, nxt_refused;
    logic [tlc_pkg::VAL_W-1:0] lo_bin, hi_bin;
    logic [tlc_pkg::VAL_W+6:0] cap_x110, lo_x100, hi_x100, smp_x100;
    logic commit_ok;
    logic [tlc_pkg::BCD_W-1:0] cur_buf, stepped_buf;

    tlc_bcd_to_bin u_lo (.bcd_in(buf_lo_ff), .bin_out(lo_bin));
    tlc_bcd_to_bin u_hi (.bcd_in(buf_hi_ff), .bin_out(hi_bin));

    // percent arithmetic widened so 110 percent never wraps
    assign cap_x110 = (tlc_pkg::VAL_W+7)'(capacity_in) * tlc_pkg::PCT_OVER;
    assign lo_x100 = (tlc_pkg::VAL_W+7)'(lo_bin) * tlc_pkg::PCT_FULL;
    assign hi_x100 = (tlc_pkg::VAL_W+7)'(hi_bin) * tlc_pkg::PCT_FULL;
    assign smp_x100 = (tlc_pkg::VAL_W+7)'(sample_in) * tlc_pkg::PCT_FULL;
    assign commit_ok = (lo_bin <= hi_bin)
                     && (lo_x100 <= cap_x110) && (hi_x100 <= cap_x110);

    always_comb begin
        cur_buf = (state_ff == tlc_pkg::TLC_EDIT_HI) ? buf_hi_ff : buf_lo_ff;
        stepped_buf = cur_buf;
        // digit wraps 9 to 0 so a single key reaches every value
        if (cur_buf[digit_ff*tlc_pkg::DIG_W +: tlc_pkg::DIG_W] == tlc_pkg::DIGIT_MAX) begin
            stepped_buf[digit_ff*tlc_pkg::DIG_W +: tlc_pkg::DIG_W] = '0;
        end else begin
            stepped_buf[digit_ff*tlc_pkg::DIG_W +: tlc_pkg::DIG_W] =
                cur_buf[digit_ff*tlc_pkg::DIG_W +: tlc_pkg::DIG_W] + 4'h1;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_digit = digit_ff;
        nxt_buf_lo = buf_lo_ff;
        nxt_buf_hi = buf_hi_ff;
        nxt_lim_lo = lim_lo_ff;
        nxt_lim_hi = lim_hi_ff;
        nxt_en = en_ff;
        nxt_refused = refused_ff;
        unique case (state_ff)
            tlc_pkg::TLC_IDLE: begin
                if (key_preset_in) begin
                    nxt_state = tlc_pkg::TLC_EDIT_LO;
                    nxt_digit = '0;
                    nxt_refused = 1'b0;
                end
            end
            tlc_pkg::TLC_EDIT_LO, tlc_pkg::TLC_EDIT_HI: begin
                if (key_cancel_in) begin
                    // pending digits are dropped, stored limits untouched
                    nxt_state = tlc_pkg::TLC_IDLE;
                    nxt_buf_lo = '0;
                    nxt_buf_hi = '0;
                end else if (key_confirm_in) begin
                    if (commit_ok) begin
                        nxt_lim_lo = lo_bin;
                        nxt_lim_hi = hi_bin;
                        nxt_en = 1'b1;
                        nxt_state = tlc_pkg::TLC_IDLE;
                    end else begin
                        nxt_refused = 1'b1;
                    end
                end else if (key_step_in) begin
                    if (state_ff == tlc_pkg::TLC_EDIT_HI) begin
                        nxt_buf_hi = stepped_buf;
                    end else begin
                        nxt_buf_lo = stepped_buf;
                    end
                end else if (key_next_in) begin
                    // past the last digit the other limit is selected
                    if (digit_ff == tlc_pkg::IDX_LAST) begin
                        nxt_digit = '0;
                        nxt_state = (state_ff == tlc_pkg::TLC_EDIT_LO) ?
                            tlc_pkg::TLC_EDIT_HI : tlc_pkg::TLC_EDIT_LO;
                    end else begin
                        nxt_digit = digit_ff + 3'h1;
                    end
                end
            end
            default: nxt_state = tlc_pkg::TLC_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            state_ff <= tlc_pkg::TLC_IDLE;
            digit_ff <= '0;
            buf_lo_ff <= '0;
            buf_hi_ff <= '0;
            lim_lo_ff <= tlc_pkg::LIMIT_RESET;
            lim_hi_ff <= tlc_pkg::LIMIT_RESET;
            en_ff <= 1'b0;
            refused_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            digit_ff <= nxt_digit;
            buf_lo_ff <= nxt_buf_lo;
            buf_hi_ff <= nxt_buf_hi;
            lim_lo_ff <= nxt_lim_lo;
            lim_hi_ff <= nxt_lim_hi;
            en_ff <= nxt_en;
            refused_ff <= nxt_refused;
        end
    end

    // ----------------------------------------
    // judgement
    // ----------------------------------------
    logic under_ff, nxt_under, over_ff, nxt_over;
    tlc_pkg::tlc_judge_t judge_ff, nxt_judge;

    always_comb begin
        nxt_under = under_ff;
        nxt_over = over_ff;
        nxt_judge = judge_ff;
        if (sample_valid_in) begin
            // capacity overload flags even before limits exist
            nxt_over = (en_ff && sample_in > lim_hi_ff) || (smp_x100 > cap_x110);
            nxt_under = en_ff && (sample_in < lim_lo_ff) && !nxt_over;
            if (nxt_over) begin
                nxt_judge = tlc_pkg::TLC_J_OVER;
            end else if (nxt_under) begin
                nxt_judge = tlc_pkg::TLC_J_UNDER;
            end else if (en_ff) begin
                nxt_judge = tlc_pkg::TLC_J_PASS;
            end else begin
                nxt_judge = tlc_pkg::TLC_J_NONE;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            under_ff <= 1'b0;
            over_ff <= 1'b0;
            judge_ff <= tlc_pkg::TLC_J_NONE;
        end else begin
            under_ff <= nxt_under;
            over_ff <= nxt_over;
            judge_ff <= nxt_judge;
        end
    end

    assign editing_out = (state_ff != tlc_pkg::TLC_IDLE);
    assign edit_high_out = (state_ff == tlc_pkg::TLC_EDIT_HI);
    assign digit_sel_out = digit_ff;
    assign edit_bcd_out = cur_buf;
    assign commit_refused_out = refused_ff;
    assign judge_enabled_out = en_ff;
    assign limit_low_out = lim_lo_ff;
    assign limit_high_out = lim_hi_ff;
    assign under_limit_switch_out = under_ff;
    assign over_limit_switch_out = over_ff;
    assign pass_fail_judgement_out = judge_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_order;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        en_ff |-> lim_lo_ff <= lim_hi_ff;
    endproperty
    a_order: assert property (p_order) else $error("stored low above high");
    property p_cap;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        $rose(en_ff) || $changed(lim_hi_ff) |-> (tlc_pkg::PCT_FULL * lim_hi_ff) <= cap_x110;
    endproperty
    a_cap: assert property (p_cap) else $error("limit above 110 percent");
    property p_under;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        sample_valid_in && en_ff && sample_in < lim_lo_ff && smp_x100 <= cap_x110
            && sample_in <= lim_hi_ff |=> under_limit_switch_out;
    endproperty
    a_under: assert property (p_under) else $error("under switch missed");
    property p_over;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        sample_valid_in && smp_x100 > cap_x110 |=> over_limit_switch_out;
    endproperty
    a_over: assert property (p_over) else $error("overload not flagged");
    property p_enable;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        !en_ff && editing_out && !key_cancel_in && key_confirm_in && commit_ok
            |=> judge_enabled_out;
    endproperty
    a_enable: assert property (p_enable) else $error("judgement not enabled");
    sequence s_step;
        editing_out && !key_cancel_in && !key_confirm_in && key_step_in;
    endsequence
    property p_step;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        s_step |=> $changed(edit_bcd_out) && $stable(digit_sel_out);
    endproperty
    a_step: assert property (p_step) else $error("step key had no effect");
    property p_cancel;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        editing_out && key_cancel_in |=> !editing_out && $stable(limit_low_out)
            && $stable(limit_high_out);
    endproperty
    a_cancel: assert property (p_cancel) else $error("cancel altered limits");
    property p_pass;
        @(posedge clk_sys_in) disable iff (!reset_n_in)
        pass_fail_judgement_out == tlc_pkg::TLC_J_PASS |-> !under_limit_switch_out
            && !over_limit_switch_out;
    endproperty
    a_pass: assert property (p_pass) else $error("switch on while passing");
endmodule : tlc_comparator

/* verif/tlc_line_model.sv */
// line controller model sensing the two comparison switches
// assumes active-high switch outputs and a shared common return
`timescale 1ns/1ps
module tlc_line_model (
    input wire logic under_in,
    input wire logic over_in,
    output logic sense_b_n_out,
    output logic sense_a_n_out
);
    // pulled-up inputs read low only while a switch conducts
    assign sense_b_n_out = ~under_in;
    assign sense_a_n_out = ~over_in;
endmodule : tlc_line_model

/* verif/tolerance_limit_comparator_test.sv */
// self-checking bench for the tolerance limit comparator
// assumes the package and the line model are compiled first
`timescale 1ns/1ps
module tolerance_limit_comparator_test;
    typedef struct packed {logic [19:0] v; logic u; logic o; logic [1:0] j;} tlc_row_t;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic sample_valid_in = 1'b0;
    logic [4:0] keys = 5'h00;
    logic [19:0] sample_in = 20'h00000;
    logic [19:0] capacity_in = 20'h003E8;
    logic editing, edit_high, refused, enabled, und, ovr, sb_n, sa_n;
    logic [2:0] sel;
    logic [19:0] bcd, lo, hi;
    logic [1:0] jud;
    int fail_count = 0;
    int check_count = 0;
    tlc_row_t rows [5] = '{'{20'h000C7, 1'b1, 1'b0, 2'h1}, '{20'h000C8, 1'b0, 1'b0, 2'h2},
        '{20'h00320, 1'b0, 1'b0, 2'h2}, '{20'h00321, 1'b0, 1'b1, 2'h3},
        '{20'h00000, 1'b1, 1'b0, 2'h1}};
    always #25 clk_sys_in = ~clk_sys_in;
    tlc_comparator i_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .capacity_in(capacity_in), .sample_valid_in(sample_valid_in), .sample_in(sample_in),
        .key_preset_in(keys[0]), .key_step_in(keys[1]), .key_next_in(keys[2]),
        .key_cancel_in(keys[3]), .key_confirm_in(keys[4]), .editing_out(editing),
        .edit_high_out(edit_high), .digit_sel_out(sel), .edit_bcd_out(bcd),
        .commit_refused_out(refused), .judge_enabled_out(enabled), .limit_low_out(lo),
        .limit_high_out(hi), .under_limit_switch_out(und), .over_limit_switch_out(ovr),
        .pass_fail_judgement_out(jud));
    tlc_line_model i_line (.under_in(und), .over_in(ovr), .sense_b_n_out(sb_n),
        .sense_a_n_out(sa_n));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chkv(input logic [19:0] got, input logic [19:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : chkv
    task automatic chkb(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chkb
    task automatic press(input int k);
        @(posedge clk_sys_in) keys <= 5'(1 << k);
        @(posedge clk_sys_in) keys <= 5'h00;
        @(negedge clk_sys_in);
    endtask : press
    // digits go in least significant first; steps count from the digit shown,
    // since a good commit leaves the edit buffers holding the old limits
    task automatic enter(input int l, input int h);
        int v;
        int d;
        press(0);
        for (int n = 0; n < 10; n++) begin
            v = (n < 5) ? l : h;
            d = (v / (10 ** (n % 5))) % 10 - int'(bcd[(n % 5) * 4 +: 4]);
            repeat ((d + 10) % 10) press(1);
            press(2);
        end
        press(4);
    endtask : enter
    task automatic judge(input logic [19:0] v, input logic u, input logic o);
        @(posedge clk_sys_in);
        sample_in <= v;
        sample_valid_in <= 1'b1;
        @(posedge clk_sys_in) sample_valid_in <= 1'b0;
        @(negedge clk_sys_in);
        chkb(und, u);
        chkb(ovr, o);
        chkb(sb_n, ~u);
        chkb(sa_n, ~o);
    endtask : judge
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        fail_count++;
        $display("ERROR %0t watchdog expired", $time);
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        @(negedge clk_sys_in);
        chkb(enabled, 1'b0);
        judge(20'h0044D, 1'b0, 1'b1);
        chkv(20'(jud), 20'h00003);
        judge(20'h0044C, 1'b0, 1'b0);
        judge(20'h00000, 1'b0, 1'b0);
        enter(200, 800);
        chkb(enabled, 1'b1);
        chkb(editing, 1'b0);
        chkv(lo, 20'h000C8);
        chkv(hi, 20'h00320);
        foreach (rows[i]) begin
            judge(rows[i].v, rows[i].u, rows[i].o);
            chkv(20'(jud), 20'(rows[i].j));
        end
        enter(900, 100);
        chkb(refused, 1'b1);
        chkb(editing, 1'b1);
        press(3);
        chkb(editing, 1'b0);
        chkv(lo, 20'h000C8);
        enter(0, 1101);
        chkb(refused, 1'b1);
        chkv(hi, 20'h00320);
        press(3);
        press(0);
        press(1);
        chkv(bcd, 20'h00001);
        press(2);
        chkv(20'(sel), 20'h00001);
        chkb(edit_high, 1'b0);
        repeat (4) press(2);
        chkb(edit_high, 1'b1);
        chkv(20'(sel), 20'h00000);
        press(3);
        chkv(lo, 20'h000C8);
        enter(100, 1100);
        chkv(hi, 20'h0044C);
        judge(20'h0044C, 1'b0, 1'b0);
        chkv(20'(jud), 20'h00002);
        judge(20'h00063, 1'b1, 1'b0);
        complete_run();
    end
endmodule : tolerance_limit_comparator_test
